/* core/signal_measure_timer_regs.sv */
// signal measurement timer: source select, counter, capture latches, period match
// Notes on behaviour
// - codes 0..16 pick pin, timers, matches, ccp, pwm
// - 17..24 oscillator, comparators, zero cross, cells
// - own match code behaves as reserved
// - selector bits 7..5 read zero, ignore writes
// - 24-bit counter, byte writable, resets to zero
// - captured period is read only, unset at reset
// - captured width is read only, unset at reset
// - period match writable, all ones after reset
// - match wraps to zero, or halts; interrupt
// - polarity bit inverts measured signal and edge
// - disable resets sequencing, keeps register contents
// - manual reset clears counter and its own flag on the same edge
//
// The Wishbone slave port and the register offsets were decided locally.
`include "smt_defs.svh"
`default_nettype none
module signal_measure_timer_regs
  import smt_pkg::*;
#(
  parameter int unsigned INSTANCE = 0  // 0 or 1: which match code is our own
) (
  // clock and reset
  input  wire logic        ref_clk_in,
  input  wire logic        nrst_in,
  // wishbone classic slave
  input  wire logic        wb_cyc_in,
  input  wire logic        wb_stb_in,
  input  wire logic        wb_we_in,
  input  wire logic [7:0]  wb_adr_in,
  input  wire logic [3:0]  wb_sel_in,
  input  wire logic [31:0] wb_dat_in,
  output logic      [31:0] wb_dat_out,
  output logic             wb_ack_out,
  // measured signal sources
  input  wire logic        pin_routed_signal_input_in,
  input  wire logic        timer_zero_wrap_in,
  input  wire logic [5:0]  timer_postscaled_in,
  input  wire logic [1:0]  measure_timer_match_in,
  input  wire logic [4:0]  capture_compare_out_in,
  input  wire logic [1:0]  pwm_out_in,
  input  wire logic        numeric_oscillator_out_in,
  input  wire logic [1:0]  comparator_synced_in,
  input  wire logic        zero_cross_out_in,
  input  wire logic [3:0]  logic_cell_out_in,
  // upper period byte held elsewhere
  input  wire logic [7:0]  period_match_upper_in,
  // events
  output logic             measure_timer_match_out,
  output logic             irq_out
);

  // the selector code that names this instance's own match
  localparam logic [4:0] OWN_MATCH = 5'(`SEL_MATCH_BASE + INSTANCE);

  // only two instances exist, so only two match codes
  if (INSTANCE > 1) begin : g_bad_instance
    $error("INSTANCE must be 0 or 1");
  end

  // pick byte n of a 24-bit value
  function automatic logic [7:0] byte_of(input logic [23:0] v, input logic [1:0] n);
    byte_of = v[8*n +: 8];
  endfunction : byte_of

  // state
  logic [4:0]  signal_source_select;  // selector code
  logic [23:0] running_count;         // the counter
  logic [23:0] captured_period_value; // no reset: undefined until first capture
  logic [23:0] captured_width_value;  // no reset: undefined until first capture
  logic [7:0]  period_match_low;      // period bits 7..0
  logic [7:0]  period_match_high;     // period bits 15..8
  ctrl_s       ctrl;                  // control bits
  logic [2:0]  irq_status;            // sticky events
  logic [2:0]  irq_mask;              // enables onto irq_out
  meas_state_e state;                 // measurement sequencing
  logic [24:0] src_meta;              // first synchroniser stage
  logic [24:0] src_sync;              // second synchroniser stage
  logic        sig_prev;              // last measured level

  // bus decode
  wire req      = wb_cyc_in & wb_stb_in;
  wire wr_go    = req & wb_we_in & wb_ack_out & wb_sel_in[0];
  wire rd_go    = req & ~wb_we_in & wb_ack_out;
  wire [7:0] wd = wb_dat_in[7:0];
  wire hit_sel  = wb_adr_in == `OFS_SIGNAL_SELECT;
  wire hit_cl   = wb_adr_in == `OFS_COUNT_LOW;
  wire hit_ch   = wb_adr_in == `OFS_COUNT_HIGH;
  wire hit_cu   = wb_adr_in == `OFS_COUNT_UPPER;
  wire hit_pl   = wb_adr_in == `OFS_PMATCH_LOW;
  wire hit_ph   = wb_adr_in == `OFS_PMATCH_HIGH;
  wire hit_ctl  = wb_adr_in == `OFS_CONTROL;
  wire hit_ist  = wb_adr_in == `OFS_IRQ_STATUS;
  wire hit_imk  = wb_adr_in == `OFS_IRQ_MASK;
  wire wr_cnt   = wr_go & (hit_cl | hit_ch | hit_cu);
  wire wr_ctl   = wr_go & hit_ctl;

  // source vector, bit index equals selector code
  // codes 0 to 24
  wire [24:0] src_raw = {logic_cell_out_in, zero_cross_out_in, comparator_synced_in,
                         numeric_oscillator_out_in, pwm_out_in, capture_compare_out_in,
                         measure_timer_match_in, timer_postscaled_in, timer_zero_wrap_in,
                         pin_routed_signal_input_in};

  wire sel_valid = (signal_source_select <= `SEL_LAST) &
                   (signal_source_select != OWN_MATCH);
  wire sig_act   = sel_valid & (src_sync[signal_source_select] ^ ctrl.signal_polarity);
  wire run       = ctrl.enable & ctrl.go;
  wire rise      = run & sig_act & ~sig_prev;
  wire fall      = run & ~sig_act & sig_prev;
  wire [23:0] period = {period_match_upper_in, period_match_high, period_match_low};
  wire match_hit = run & (running_count == period);
  wire cap_per   = rise & (state != MS_WAIT);
  wire cap_wid   = fall & (state == MS_ACTIVE);

  // next counter value, bus write first
  logic [23:0] next_count;
  always_comb begin
    next_count = running_count;
    if (wr_cnt) begin
      if (hit_cl) next_count[7:0] = wd;
      if (hit_ch) next_count[15:8] = wd;
      if (hit_cu) next_count[23:16] = wd;
    end else if (ctrl.manual_reset) begin
      next_count = `RST_COUNT;
    end else if (rise) begin
      // a new cycle of the signal restarts the count
      next_count = `RST_COUNT;
    end else if (match_hit) begin
      next_count = ctrl.halt_at_match ? running_count : `RST_COUNT;
    end else if (run) begin
      next_count = running_count + 24'h000001;
    end
  end

  // interrupt bookkeeping; a read of status clears, a new event wins
  wire [2:0] events = {cap_wid, cap_per, match_hit};
  wire [2:0] next_status = (rd_go & hit_ist) ? events : (irq_status | events);

  // read mux, unmapped addresses read zero
  logic [7:0] rd_byte;
  always_comb begin
    case (wb_adr_in)
      `OFS_SIGNAL_SELECT: rd_byte = {3'h0, signal_source_select};
      `OFS_COUNT_LOW:     rd_byte = byte_of(running_count, 2'h0);
      `OFS_COUNT_HIGH:    rd_byte = byte_of(running_count, 2'h1);
      `OFS_COUNT_UPPER:   rd_byte = byte_of(running_count, 2'h2);
      `OFS_CPER_LOW:      rd_byte = byte_of(captured_period_value, 2'h0);
      `OFS_CPER_HIGH:     rd_byte = byte_of(captured_period_value, 2'h1);
      `OFS_CPER_UPPER:    rd_byte = byte_of(captured_period_value, 2'h2);
      `OFS_CWID_LOW:      rd_byte = byte_of(captured_width_value, 2'h0);
      `OFS_CWID_HIGH:     rd_byte = byte_of(captured_width_value, 2'h1);
      `OFS_CWID_UPPER:    rd_byte = byte_of(captured_width_value, 2'h2);
      `OFS_PMATCH_LOW:    rd_byte = period_match_low;
      `OFS_PMATCH_HIGH:   rd_byte = period_match_high;
      `OFS_CONTROL:       rd_byte = {3'h0, ctrl};
      `OFS_IRQ_STATUS:    rd_byte = {5'h00, irq_status};
      `OFS_IRQ_MASK:      rd_byte = {5'h00, irq_mask};
      default:            rd_byte = 8'h00;
    endcase
  end

  // bus answer: ack one cycle after the request, data with it
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wb_ack_out <= 1'b0;
      wb_dat_out <= 32'h00000000;
    end else begin
      wb_ack_out <= req & ~wb_ack_out;
      if (req & ~wb_ack_out) wb_dat_out <= {24'h000000, rd_byte};
    end
  end

  // two-flop synchroniser; sources may come from other clocks or a pin
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      src_meta <= 25'h0;
      src_sync <= 25'h0;
    end else begin
      src_meta <= src_raw;
      src_sync <= src_meta;
    end
  end

  // selector register
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      signal_source_select <= `RST_SELECT;
    end else if (wr_go & hit_sel) begin
      signal_source_select <= wd[4:0];
    end
  end

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) running_count <= `RST_COUNT;
    else running_count <= next_count;
  end

  // capture latches carry no reset, so reads before a capture are undefined
  // only the capture events load them; the bus has no write path here
  always_ff @(posedge ref_clk_in) begin
    if (cap_per) captured_period_value <= running_count;
    if (cap_wid) captured_width_value <= running_count;
  end

  // period bytes come up all ones
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      period_match_low  <= `RST_PMATCH;
      period_match_high <= `RST_PMATCH;
    end else begin
      if (wr_go & hit_pl) period_match_low <= wd;
      if (wr_go & hit_ph) period_match_high <= wd;
    end
  end

  // control bits; a software write of the flag wins over its hardware clear
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ctrl <= '0;
    end else if (wr_ctl) begin
      ctrl.enable          <= wd[`CTL_ENABLE];
      ctrl.go              <= wd[`CTL_GO];
      ctrl.halt_at_match   <= wd[`CTL_HALT];
      ctrl.signal_polarity <= wd[`CTL_POLARITY];
      ctrl.manual_reset    <= wd[`CTL_MRESET];
    end else if (ctrl.manual_reset) begin
      // flag drops once the counter is cleared
      ctrl.manual_reset <= 1'b0;
    end
  end

  // interrupt status, mask and level output
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      irq_status <= `RST_IRQ;
      irq_mask   <= `RST_IRQ;
      irq_out    <= 1'b0;
    end else begin
      irq_status <= next_status;
      if (wr_go & hit_imk) irq_mask <= wd[2:0];
      irq_out <= |(next_status & irq_mask);
    end
  end

  // measurement sequencing and match pulse
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state    <= MS_WAIT;
      sig_prev <= 1'b0;
      measure_timer_match_out <= 1'b0;
    end else begin
      measure_timer_match_out <= match_hit;
      sig_prev <= ctrl.enable & sig_act;
      if (!ctrl.enable) begin
        // disable returns to waiting, registers untouched
        state <= MS_WAIT;
      end else begin
        case (state)
          MS_WAIT:     if (rise) state <= MS_ACTIVE;
          MS_ACTIVE:   if (fall) state <= MS_INACTIVE;
          MS_INACTIVE: if (rise) state <= MS_ACTIVE;
          default:     state <= MS_WAIT;
        endcase
      end
    end
  end

  // checks
  property p_sel_reserved;
    @(posedge ref_clk_in) disable iff (!nrst_in)
      (signal_source_select > `SEL_LAST) |-> (!rise && !cap_per) ##1 !sig_prev;
  endproperty
  a_sel_reserved: assert property (p_sel_reserved) else $error("reserved code gave edge");

  property p_own_match;
    @(posedge ref_clk_in) disable iff (!nrst_in)
      (signal_source_select == OWN_MATCH) |-> !sig_act;
  endproperty
  a_own_match: assert property (p_own_match) else $error("own match was selected");

  property p_sel_read;
    @(posedge ref_clk_in) disable iff (!nrst_in)
      $past(req && !wb_we_in && hit_sel && !wb_ack_out) && wb_ack_out
        |-> wb_dat_out == {27'h0000000, signal_source_select};
  endproperty
  a_sel_read: assert property (p_sel_read) else $error("selector readback wrong");

  property p_count_inc;
    @(posedge ref_clk_in) disable iff (!nrst_in)
      run && !match_hit && !rise && !wr_cnt && !ctrl.manual_reset
        |=> running_count == $past(running_count) + 24'h000001;
  endproperty
  a_count_inc: assert property (p_count_inc) else $error("counter did not step");

  property p_period_cap;
    @(posedge ref_clk_in) disable iff (!nrst_in)
      cap_per && !wr_cnt
        |=> captured_period_value == $past(running_count) && running_count == 24'h0;
  endproperty
  a_period_cap: assert property (p_period_cap) else $error("period not captured");

  property p_width_cap;
    @(posedge ref_clk_in) disable iff (!nrst_in)
      cap_wid |=> captured_width_value == $past(running_count) && irq_status[`IRQ_WIDTH];
  endproperty
  a_width_cap: assert property (p_width_cap) else $error("width not captured");

  property p_latch_ro;
    @(posedge ref_clk_in) disable iff (!nrst_in)
      wr_go && !cap_per && (wb_adr_in == `OFS_CPER_LOW) |=> $stable(captured_period_value);
  endproperty
  a_latch_ro: assert property (p_latch_ro) else $error("latch took a write");

  property p_wrap;
    @(posedge ref_clk_in) disable iff (!nrst_in)
      match_hit && !ctrl.halt_at_match && !wr_cnt
        |=> running_count == 24'h0 && irq_status[`IRQ_MATCH] && measure_timer_match_out;
  endproperty
  a_wrap: assert property (p_wrap) else $error("no wrap at match");

  property p_halt;
    @(posedge ref_clk_in) disable iff (!nrst_in)
      match_hit && ctrl.halt_at_match && !wr_cnt && !rise && !ctrl.manual_reset
        |=> $stable(running_count);
  endproperty
  a_halt: assert property (p_halt) else $error("no halt at match");

  property p_polarity;
    @(posedge ref_clk_in) disable iff (!nrst_in)
      signal_source_select == 5'h00 && ctrl.signal_polarity |-> sig_act == !src_sync[0];
  endproperty
  a_polarity: assert property (p_polarity) else $error("polarity not applied");

  property p_disable;
    @(posedge ref_clk_in) disable iff (!nrst_in)
      !ctrl.enable && !wr_cnt && !ctrl.manual_reset
        |=> state == MS_WAIT && $stable(running_count);
  endproperty
  a_disable: assert property (p_disable) else $error("disable misbehaved");

  property p_manual_reset;
    @(posedge ref_clk_in) disable iff (!nrst_in)
      ctrl.manual_reset && !wr_cnt && !wr_ctl |=> running_count == 24'h0 && !ctrl.manual_reset;
  endproperty
  a_manual_reset: assert property (p_manual_reset) else $error("manual reset failed");

endmodule : signal_measure_timer_regs
`default_nettype wire

/* core/smt_defs.svh */
// register offsets, field positions, codes and reset values of the measure timer
`ifndef SMT_DEFS_SVH
`define SMT_DEFS_SVH
// byte addresses of the word registers
`define OFS_SIGNAL_SELECT 8'h00
`define OFS_COUNT_LOW     8'h04
`define OFS_COUNT_HIGH    8'h08
`define OFS_COUNT_UPPER   8'h0C
`define OFS_CPER_LOW      8'h10
`define OFS_CPER_HIGH     8'h14
`define OFS_CPER_UPPER    8'h18
`define OFS_CWID_LOW      8'h1C
`define OFS_CWID_HIGH     8'h20
`define OFS_CWID_UPPER    8'h24
`define OFS_PMATCH_LOW    8'h28
`define OFS_PMATCH_HIGH   8'h2C
`define OFS_CONTROL       8'h30
`define OFS_IRQ_STATUS    8'h34
`define OFS_IRQ_MASK      8'h38
// control register bit positions
`define CTL_ENABLE   0
`define CTL_GO       1
`define CTL_HALT     2
`define CTL_POLARITY 3
`define CTL_MRESET   4
// interrupt status / mask bit positions
`define IRQ_MATCH  0
`define IRQ_PERIOD 1
`define IRQ_WIDTH  2
// selector codes
`define SEL_MATCH_BASE 5'h08
`define SEL_LAST       5'h18
// reset values
`define RST_SELECT 5'h00
`define RST_COUNT  24'h000000
`define RST_PMATCH 8'hFF
`define RST_IRQ    3'h0
`endif

/* core/smt_pkg.sv */
// types shared by the signal measurement timer register block
`default_nettype none
package smt_pkg;
  // software control bits of the block
  typedef struct packed {
    logic manual_reset;
    logic signal_polarity;
    logic halt_at_match;
    logic go;
    logic enable;
  } ctrl_s;
  // measurement sequencing
  typedef enum logic [1:0] {MS_WAIT, MS_ACTIVE, MS_INACTIVE} meas_state_e;
endpackage : smt_pkg
`default_nettype wire

/* tb/smt_source_model.sv */
// stand-in for the on-chip sources that feed the measured signal selector
`default_nettype none
module smt_source_model (
  // clock and reset
  input  wire logic        ref_clk_in,
  input  wire logic        nrst_in,
  // which source carries the bench waveform, and its level
  input  wire logic [4:0]  code_in,
  input  wire logic        level_in,
  // all source lines, bit n feeds selector code n
  output logic      [31:0] src_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] noise;  // unselected sources, toggling every cycle
  // free-running peripherals never sit still, so a wrong pick shows as a short period
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      noise <= 32'h55555555;
    end else begin
      noise <= ~noise;
    end
  end
  always_comb begin
    src_out = noise;
    src_out[code_in] = level_in;
  end
endmodule : smt_source_model
`default_nettype wire

/* tb/test_signal_measure_timer_regs.sv */
// self-checking bench of the signal measurement timer register block
`default_nettype none
module test_signal_measure_timer_regs;
  timeunit 1ns;
  timeprecision 1ns;
  // bus master, reset and stimulus state
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h00000000;
  logic [3:0]  sel = 4'hF;         // byte enables
  logic [31:0] rdat;
  logic        ack;
  logic        irq;
  logic        match;
  logic [4:0]  code = 5'h00;       // source the partner drives
  logic        lvl = 1'b0;         // waveform on that source
  logic [7:0]  pm_upper = 8'hFF;   // upper period byte
  logic [31:0] src;
  logic [31:0] seed = 32'h98D8A027;
  int          errors = 0;
  int          num_checks = 0;
  int          cycles = 0;
  int          last = 0;           // model of the last captured period

  smt_source_model i_src (.ref_clk_in(clk), .nrst_in(nrst), .code_in(code),
    .level_in(lvl), .src_out(src));

  signal_measure_timer_regs #(.INSTANCE(0)) i_dut (
    .ref_clk_in(clk), .nrst_in(nrst), .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we),
    .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat), .wb_dat_out(rdat),
    .wb_ack_out(ack), .pin_routed_signal_input_in(src[0]), .timer_zero_wrap_in(src[1]),
    .timer_postscaled_in(src[7:2]), .measure_timer_match_in(src[9:8]),
    .capture_compare_out_in(src[14:10]), .pwm_out_in(src[16:15]),
    .numeric_oscillator_out_in(src[17]), .comparator_synced_in(src[19:18]),
    .zero_cross_out_in(src[20]), .logic_cell_out_in(src[24:21]),
    .period_match_upper_in(pm_upper), .measure_timer_match_out(match), .irq_out(irq));

  // 20 MHz clock
  initial begin
    forever #25 clk = ~clk;
  end

  // hang guard, well above the few thousand cycles the run needs
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      complete_run();
    end
  end

  function automatic logic [31:0] xorshift();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xorshift

  // one classic cycle; waits on ack, takes data at that edge, then releases
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h000000, d};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) errors++;
    q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  // register read compared with the model
  task automatic chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] q;
    bus(1'b0, a, 8'h00, q);
    num_checks++;
    if (q !== exp) begin
      errors++;
      $display("[FAIL] t=%0t reg %h got %h exp %h", $time, a, q, exp);
    end
  endtask : chk

  // interrupt line compared with the model
  task automatic chk_irq(input logic exp);
    num_checks++;
    if (irq !== exp) begin
      errors++;
      $display("[FAIL] t=%0t irq got %h exp %h", $time, irq, exp);
    end
  endtask : chk_irq

  // match output compared with the model
  task automatic chk_match(input logic exp);
    num_checks++;
    if (match !== exp) begin
      errors++;
      $display("[FAIL] t=%0t match got %h exp %h", $time, match, exp);
    end
  endtask : chk_match

  // three pulses on one selector code, then captures, status and irq
  task automatic measure(input int c);
    int         h;
    int         l;
    logic       valid;
    logic       pol;
    logic [7:0] q;
    h = 2 + int'(xorshift() % 32'd8);
    l = 2 + int'(xorshift() % 32'd8);
    valid = (c <= 24 && c != 8);
    pol = c[0];
    // stop counting first, so a change of source or level cannot capture
    wr(8'h30, 8'h00);
    lvl <= pol;
    wr(8'h00, 8'(c));
    code <= 5'(c);
    bus(1'b0, 8'h34, 8'h00, q);
    wr(8'h30, {4'h0, pol, 3'b011});
    repeat (4) @(posedge clk);
    repeat (3) begin
      lvl <= !pol;
      repeat (h) @(posedge clk);
      lvl <= pol;
      repeat (l) @(posedge clk);
    end
    repeat (6) @(posedge clk);
    chk_irq(valid);
    chk(8'h34, valid ? 8'h06 : 8'h00);
    if (valid) begin
      last = h + l - 1;
      chk(8'h10, 8'(last));
      chk(8'h14, 8'h00);
      chk(8'h18, 8'h00);
      chk(8'h1C, 8'(h - 1));
      chk(8'h24, 8'h00);
    end
    chk_irq(1'b0);
    chk_match(1'b0);
  endtask : measure

  task automatic complete_run();
    if (errors == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : complete_run

  // main sequence
  initial begin
    logic [7:0] r;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    chk(8'h00, 8'h00);
    chk(8'h04, 8'h00);
    chk(8'h08, 8'h00);
    chk(8'h0C, 8'h00);
    chk(8'h28, 8'hFF);
    chk(8'h2C, 8'hFF);
    chk_irq(1'b0);
    r = 8'(xorshift());
    wr(8'h00, r | 8'hE0);
    chk(8'h00, r & 8'h1F);
    wr(8'h04, r);
    wr(8'h08, ~r);
    wr(8'h0C, 8'h3C);
    chk(8'h04, r);
    chk(8'h08, ~r);
    chk(8'h0C, 8'h3C);
    wr(8'h2C, r);
    chk(8'h2C, r);
    // a write without byte lane 0 leaves the register alone
    sel <= 4'hE;
    wr(8'h2C, ~r);
    sel <= 4'hF;
    chk(8'h2C, r);
    wr(8'h2C, 8'hFF);
    wr(8'h3C, 8'hFF);
    chk(8'h3C, 8'h00);
    wr(8'h38, 8'h06);
    for (int c = 0; c < 32; c++) begin
      measure(c);
    end
    // disabled block keeps latches and config; latch writes ignored
    wr(8'h30, 8'h00);
    wr(8'h10, ~8'(last));
    chk(8'h10, 8'(last));
    chk(8'h00, 8'h1F);
    // period match wraps, then halts
    pm_upper <= 8'h00;
    wr(8'h28, 8'h0A);
    wr(8'h2C, 8'h00);
    wr(8'h04, 8'h00);
    wr(8'h08, 8'h00);
    wr(8'h0C, 8'h00);
    bus(1'b0, 8'h34, 8'h00, r);
    wr(8'h38, 8'h07);
    wr(8'h30, 8'h03);
    repeat (30) @(posedge clk);
    chk_irq(1'b1);
    chk(8'h34, 8'h01);
    wr(8'h30, 8'h07);
    repeat (30) @(posedge clk);
    chk_match(1'b1);
    chk(8'h04, 8'h0A);
    chk(8'h08, 8'h00);
    // manual counter reset clears itself
    wr(8'h30, 8'h01);
    wr(8'h04, 8'h55);
    wr(8'h30, 8'h11);
    chk(8'h30, 8'h01);
    chk(8'h04, 8'h00);
    complete_run();
  end
endmodule : test_signal_measure_timer_regs
`default_nettype wire
